// file: rtl/sar_unit.sv
// Purpose: Secure access remap unit, register banks and access control
// Assumes: Both buses and the master port share clk; inputs synchronous
// Notes:   Channel accesses are remapped through the master port
`timescale 1ns/1ps

// Operation
// - Control bit 0 written one switches unit on; zeros do nothing.
// - Control switch-off bit turns unit off, clears enabled flag.
// - Setup entry bit enters setup mode; setup exit bit leaves it.
// - Fault-reply on/off bits enable or stop bus errors to requester.
// - Unlock lasts window+1 cycles or until one channel access completes.
// - Unlock only when written key equals configured unlock key.
// - Lower enable bit n enables channel n; upper enables n+32.
// - Idle flag clears at channel access start, sets when done.
// - Setup and enabled status flags follow mode and on state.
// - Setup write of target outside FFFC..FFFF sets bad-target flag.
// - Master error response on channel transfer sets master fault flag.
// - Unlock write with any error flag set aborts, sets blocked flag.
// - Unlock write with mismatching key sets wrong-key flag.
// - Any read of the unlock port sets unlock-read flag.
// - Access to locked or disabled channel sets access-fail flag.
// - Access-success flag sets after one access to unlocked channel.
// - Event flags clear only by writing one to flag-clear bit.
// - Targets decode at four times channel, unlock port at FC.
// - Mask-set bits set mask; interrupt while flag and mask set.
// - One channel unlocked at a time; new unlock relocks old one.
// - Window expiry without access sets unlock-timeout flag.
// - With replies on, port read, locked access, slave error answer error.
module sar_unit #(
    parameter int          NCH     = 63,
    parameter logic [31:0] REV_VAL = 32'h00000100  // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        rst,
    // Peripheral-bus register bank
    input  wire logic        pb_sel,
    input  wire logic        pb_wr,
    input  wire logic [7:0]  pb_addr,
    input  wire logic [31:0] pb_wdata,
    output logic      [31:0] pb_rdata_r,
    output logic             pb_ready_r,
    // High-speed-bus channel slave
    input  wire logic        hs_req,
    input  wire logic        hs_wr,
    input  wire logic [7:0]  hs_addr,
    input  wire logic [31:0] hs_wdata,
    output logic      [31:0] hs_rdata_r,
    output logic             hs_done_r,
    output logic             hs_err_r,
    output logic             hs_busy_r,
    // High-speed-bus master
    output logic             m_req_r,
    output logic             m_wr_r,
    output logic      [31:0] m_addr_r,
    output logic      [31:0] m_wdata_r,
    input  wire logic [31:0] m_rdata,
    input  wire logic        m_done,
    input  wire logic        m_err,
    output logic             irq_r
);
    typedef enum logic [2:0] {
        ST_WAIT   = 3'b001,
        ST_MASTER = 3'b010,
        ST_ANSWER = 3'b100
    } sar_state_t;

    localparam int CW = sar_pkg::UNL_CHAN_W;
    localparam int FW = sar_pkg::FIELD_W;

    sar_state_t         state_r;
    logic               enabled_r;
    logic               setup_r;
    logic               reply_on_r;
    logic               open_r;
    logic [FW-1:0]      key_r;
    logic [FW-1:0]      window_r;
    logic [31:0]        on_lower_r;
    logic [31:0]        on_upper_r;
    logic [7:0]         flags_r;
    logic [7:0]         flags_set;
    logic [7:0]         mask_r;
    logic               idle_r;
    logic               unlocked_r;
    logic [CW-1:0]      unl_chan_r;
    logic [FW-1:0]      win_cnt_r;
    logic [31:0]        rtr_r [NCH];
    logic               pb_wstb;
    logic               hs_take;
    logic [CW-1:0]      hs_chan;
    logic               hs_is_port;
    logic               hs_chan_valid;
    logic               chan_allowed;
    logic               unlock_ok;
    logic               start_master;
    logic               master_end;
    logic               rtr_wstb;
    logic [31:0]        status_word;

    // Enable bit for a channel from both enable words
    function automatic logic chan_enabled(input logic [CW-1:0] ch,
                                          input logic [31:0]   lo,
                                          input logic [31:0]   hi);
        logic [5:0] idx;
        idx = ch;
        if (idx[5])
            chan_enabled = hi[idx[4:0]];
        else
            chan_enabled = lo[idx[4:0]];
    endfunction : chan_enabled

    // Channel index from a byte offset
    function automatic logic [CW-1:0] chan_of(input logic [7:0] a);
        chan_of = a[CW+1:2];
    endfunction : chan_of

    assign pb_wstb       = pb_sel && pb_wr;
    assign hs_take       = hs_req && (state_r == ST_WAIT);
    assign hs_is_port    = (hs_addr == sar_pkg::OFF_UNLOCK_PORT);
    assign hs_chan       = chan_of(hs_addr);
    assign hs_chan_valid = !hs_is_port && (32'(hs_chan) < NCH);
    assign chan_allowed  = enabled_r
                        && chan_enabled(hs_chan, on_lower_r, on_upper_r)
                        && (open_r
                            || (unlocked_r && unl_chan_r == hs_chan));
    assign unlock_ok     = hs_take && hs_is_port && hs_wr
                        && ((flags_r & sar_pkg::ERR_FLAGS_MASK) == 8'h00)
                        && (hs_wdata[sar_pkg::UNL_KEY_LSB +: FW]
                            == key_r);
    assign start_master  = hs_take && hs_chan_valid && !setup_r
                        && chan_allowed;
    assign master_end    = (state_r == ST_MASTER) && m_done;
    assign rtr_wstb      = hs_take && hs_chan_valid && setup_r && hs_wr;

    assign status_word = {21'h000000, idle_r, setup_r, enabled_r,
                          flags_r};

    // Control word actions
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enabled_r  <= 1'b0;
            setup_r    <= 1'b0;
            reply_on_r <= 1'b0;
        end
        else if (pb_wstb && pb_addr == sar_pkg::OFF_CONTROL_WORD)
        begin
            if (pb_wdata[sar_pkg::CW_UNIT_OFF])
                enabled_r <= 1'b0;
            else if (pb_wdata[sar_pkg::CW_ENABLE])
                enabled_r <= 1'b1;
            if (pb_wdata[sar_pkg::CW_SETUP_EXIT])
                setup_r <= 1'b0;
            else if (pb_wdata[sar_pkg::CW_SETUP_ENTRY])
                setup_r <= 1'b1;
            if (pb_wdata[sar_pkg::CW_FAULT_REPLY_OFF])
                reply_on_r <= 1'b0;
            else if (pb_wdata[sar_pkg::CW_FAULT_REPLY_ON])
                reply_on_r <= 1'b1;
        end
    end

    // Settings register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            open_r   <= 1'b0;
            key_r    <= '0;
            window_r <= '0;
        end
        else if (pb_wstb && pb_addr == sar_pkg::OFF_SETTINGS_REG)
        begin
            open_r   <= pb_wdata[sar_pkg::SET_OPEN];
            key_r    <= pb_wdata[sar_pkg::SET_KEY_LSB +: FW];
            window_r <= pb_wdata[sar_pkg::SET_CYC_LSB +: FW];
        end
    end

    // Channel enable words
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            on_lower_r <= sar_pkg::ZERO_WORD;
            on_upper_r <= sar_pkg::ZERO_WORD;
        end
        else if (pb_wstb)
        begin
            if (pb_addr == sar_pkg::OFF_CHAN_ON_LOWER)
                on_lower_r <= pb_wdata;
            if (pb_addr == sar_pkg::OFF_CHAN_ON_UPPER)
                on_upper_r <= pb_wdata;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk)
    begin
        if (rst)
            mask_r <= '0;
        else if (pb_wstb && pb_addr == sar_pkg::OFF_IRQ_MASK_SET)
            mask_r <= mask_r | pb_wdata[7:0];
        else if (pb_wstb && pb_addr == sar_pkg::OFF_IRQ_MASK_CLEAR)
            mask_r <= mask_r & ~pb_wdata[7:0];
    end

    // Interrupt request
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_r <= 1'b0;
        else
            irq_r <= |(flags_r & mask_r);
    end

    // Register bank read answer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pb_rdata_r <= sar_pkg::ZERO_WORD;
            pb_ready_r <= 1'b0;
        end
        else
        begin
            pb_ready_r <= pb_sel;
            pb_rdata_r <= sar_pkg::ZERO_WORD;
            if (pb_sel && !pb_wr)
            begin
                case (pb_addr)
                    sar_pkg::OFF_CHAN_ON_UPPER:
                        pb_rdata_r <= on_upper_r;
                    sar_pkg::OFF_CHAN_ON_LOWER:
                        pb_rdata_r <= on_lower_r;
                    sar_pkg::OFF_STATUS_WORD:
                        pb_rdata_r <= status_word;
                    sar_pkg::OFF_IRQ_MASK:
                        pb_rdata_r <= {24'h000000, mask_r};
                    sar_pkg::OFF_PARAMETER_INFO:
                        pb_rdata_r <= 32'(NCH);
                    sar_pkg::OFF_MODULE_REV:
                        pb_rdata_r <= REV_VAL;
                    default:
                        pb_rdata_r <= sar_pkg::ZERO_WORD;
                endcase
            end
        end
    end

    // Remap target storage
    for (genvar g = 0; g < NCH; g++)
    begin : g_rtr
        always_ff @(posedge clk)
        begin
            if (rst)
                rtr_r[g] <= sar_pkg::ZERO_WORD;
            else if (rtr_wstb && 32'(hs_chan) == g)
                rtr_r[g] <= hs_wdata;
        end
    end

    // Events raised this cycle
    always_comb
    begin
        flags_set = '0;
        if (rtr_wstb && (hs_wdata[31:16] < sar_pkg::TGT_MIN_HI
                         || hs_wdata[31:16] > sar_pkg::TGT_MAX_HI))
            flags_set[sar_pkg::ST_BADTGT] = 1'b1;
        if (master_end && m_err)
            flags_set[sar_pkg::ST_MFAULT] = 1'b1;
        if (master_end && !m_err && !open_r)
            flags_set[sar_pkg::ST_SUCCESS] = 1'b1;
        if (hs_take && hs_is_port && hs_wr)
        begin
            if ((flags_r & sar_pkg::ERR_FLAGS_MASK) != 8'h00)
                flags_set[sar_pkg::ST_BLOCKED] = 1'b1;
            else if (!unlock_ok)
                flags_set[sar_pkg::ST_WKEY] = 1'b1;
        end
        if (hs_take && hs_is_port && !hs_wr)
            flags_set[sar_pkg::ST_URD] = 1'b1;
        if (hs_take && hs_chan_valid && !setup_r && !chan_allowed)
            flags_set[sar_pkg::ST_FAIL] = 1'b1;
        if (unlocked_r && state_r != ST_MASTER && !start_master
            && !unlock_ok && win_cnt_r == '0)
            flags_set[sar_pkg::ST_TIMEOUT] = 1'b1;
    end

    // Event flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            flags_r <= sar_pkg::STATUS_RESET[7:0];
        else if (pb_wstb && pb_addr == sar_pkg::OFF_FLAG_CLEAR)
            flags_r <= (flags_r & ~pb_wdata[7:0]) | flags_set;
        else
            flags_r <= flags_r | flags_set;
    end

    // Unlock window
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            unlocked_r <= 1'b0;
            unl_chan_r <= '0;
            win_cnt_r  <= '0;
        end
        else if (unlock_ok)
        begin
            unlocked_r <= 1'b1;
            unl_chan_r <= hs_wdata[sar_pkg::UNL_CHAN_LSB +: CW];
            win_cnt_r  <= window_r;
        end
        else if (master_end)
            unlocked_r <= 1'b0;
        else if (unlocked_r && state_r != ST_MASTER && !start_master)
        begin
            if (win_cnt_r == '0)
                unlocked_r <= 1'b0;
            else
                win_cnt_r <= win_cnt_r - 1'b1;
        end
    end

    // Idle flag
    always_ff @(posedge clk)
    begin
        if (rst)
            idle_r <= sar_pkg::STATUS_RESET[sar_pkg::ST_IDLE];
        else if (start_master)
            idle_r <= 1'b0;
        else if (master_end)
            idle_r <= 1'b1;
    end

    // Channel slave sequencing
    always_ff @(posedge clk)
    begin
        if (rst)
            state_r <= ST_WAIT;
        else
        begin
            case (state_r)
                ST_WAIT:
                    if (start_master)
                        state_r <= ST_MASTER;
                    else if (hs_take)
                        state_r <= ST_ANSWER;
                ST_MASTER:
                    if (m_done)
                        state_r <= ST_ANSWER;
                ST_ANSWER:
                    state_r <= ST_WAIT;
                default:
                    state_r <= ST_WAIT;
            endcase
        end
    end

    // Master port
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            m_req_r   <= 1'b0;
            m_wr_r    <= 1'b0;
            m_addr_r  <= sar_pkg::ZERO_WORD;
            m_wdata_r <= sar_pkg::ZERO_WORD;
        end
        else if (start_master)
        begin
            m_req_r   <= 1'b1;
            m_wr_r    <= hs_wr;
            m_addr_r  <= rtr_r[hs_chan];
            m_wdata_r <= hs_wdata;
        end
        else if (master_end)
            m_req_r <= 1'b0;
    end

    // Channel slave answer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hs_done_r  <= 1'b0;
            hs_err_r   <= 1'b0;
            hs_rdata_r <= sar_pkg::ZERO_WORD;
            hs_busy_r  <= 1'b0;
        end
        else
        begin
            hs_done_r <= 1'b0;
            hs_err_r  <= 1'b0;
            hs_busy_r <= (state_r == ST_WAIT) ? hs_req
                                              : (state_r == ST_MASTER);
            if (master_end)
            begin
                hs_done_r  <= 1'b1;
                hs_err_r   <= m_err && reply_on_r;
                hs_rdata_r <= m_wr_r ? sar_pkg::ZERO_WORD : m_rdata;
            end
            else if (hs_take && !start_master)
            begin
                hs_done_r  <= 1'b1;
                hs_rdata_r <= sar_pkg::ZERO_WORD;
                if (hs_is_port && !hs_wr)
                    hs_err_r <= reply_on_r;
                else if (hs_chan_valid && !setup_r)
                    hs_err_r <= reply_on_r;
                else if (hs_chan_valid && !hs_wr)
                    hs_rdata_r <= rtr_r[hs_chan];
            end
        end
    end
endmodule : sar_unit

// file: rtl/sar_pkg.sv
// Purpose: Shared constants for the secure access remap unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Offsets are byte offsets on each bus
package sar_pkg;
    // Peripheral-bus bank offsets
    localparam logic [7:0] OFF_CONTROL_WORD   = 8'h00;
    localparam logic [7:0] OFF_SETTINGS_REG   = 8'h04;
    localparam logic [7:0] OFF_CHAN_ON_UPPER  = 8'h08;
    localparam logic [7:0] OFF_CHAN_ON_LOWER  = 8'h0C;
    localparam logic [7:0] OFF_STATUS_WORD    = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK_SET   = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK_CLEAR = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK       = 8'h1C;
    localparam logic [7:0] OFF_FLAG_CLEAR     = 8'h20;
    localparam logic [7:0] OFF_PARAMETER_INFO = 8'h24;
    localparam logic [7:0] OFF_MODULE_REV     = 8'h28;
    // High-speed-bus offsets
    localparam logic [7:0] OFF_UNLOCK_PORT    = 8'hFC;
    // Control word bits
    localparam int CW_ENABLE          = 0;
    localparam int CW_UNIT_OFF        = 1;
    localparam int CW_SETUP_ENTRY     = 2;
    localparam int CW_SETUP_EXIT      = 3;
    localparam int CW_FAULT_REPLY_ON  = 4;
    localparam int CW_FAULT_REPLY_OFF = 5;
    // Settings fields
    localparam int SET_KEY_LSB   = 0;
    localparam int SET_CYC_LSB   = 8;
    localparam int SET_OPEN      = 16;
    localparam int FIELD_W       = 8;
    // Unlock port fields
    localparam int UNL_CHAN_LSB  = 0;
    localparam int UNL_CHAN_W    = 6;
    localparam int UNL_KEY_LSB   = 8;
    // Status word bits
    localparam int ST_TIMEOUT    = 0;
    localparam int ST_SUCCESS    = 1;
    localparam int ST_FAIL       = 2;
    localparam int ST_URD        = 3;
    localparam int ST_WKEY       = 4;
    localparam int ST_BLOCKED    = 5;
    localparam int ST_MFAULT     = 6;
    localparam int ST_BADTGT     = 7;
    localparam int ST_ENABLED    = 8;
    localparam int ST_SETUP      = 9;
    localparam int ST_IDLE       = 10;
    localparam int NFLAGS        = 8;
    localparam logic [7:0] ERR_FLAGS_MASK = 8'hFD;
    localparam logic [31:0] STATUS_RESET  = 32'h00000400;
    // Legal remap target window, upper half-word
    localparam logic [15:0] TGT_MIN_HI = 16'hFFFC;
    localparam logic [15:0] TGT_MAX_HI = 16'hFFFF;
    localparam logic [31:0] ZERO_WORD  = 32'h00000000;
    localparam int CHAN_MAX = 63;
endpackage : sar_pkg

// file: bench/sar_unit_sva.sv
// Purpose: Port-level checks for the secure access remap unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every sar_unit instance
`timescale 1ns/1ps
module sar_unit_sva (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        pb_sel,
    input wire logic        pb_wr,
    input wire logic [7:0]  pb_addr,
    input wire logic [31:0] pb_rdata_r,
    input wire logic        pb_ready_r,
    input wire logic        hs_req,
    input wire logic [31:0] hs_rdata_r,
    input wire logic        hs_done_r,
    input wire logic        hs_err_r,
    input wire logic        hs_busy_r,
    input wire logic        m_req_r,
    input wire logic        m_wr_r,
    input wire logic [31:0] m_addr_r,
    input wire logic [31:0] m_rdata,
    input wire logic        m_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ready_follows_a: assert property (pb_sel |=> pb_ready_r)
        else $error("register answer missing");
    ready_only_a: assert property (!pb_sel |=> !pb_ready_r)
        else $error("register answer without request");
    wo_reads_zero_a: assert property (pb_sel && !pb_wr && (pb_addr inside
        {8'h00, 8'h04, 8'h14, 8'h18, 8'h20}) |=> pb_rdata_r == 32'h0)
        else $error("write-only register read not zero");
    quiet_rdata_a: assert property (!pb_ready_r |-> pb_rdata_r == 32'h0)
        else $error("register data outside answer");
    done_pulse_a: assert property (hs_done_r |=> !hs_done_r)
        else $error("channel answer longer than one cycle");
    err_with_done_a: assert property (hs_err_r |-> hs_done_r)
        else $error("bus error without answer");
    master_busy_a: assert property (m_req_r |-> hs_busy_r)
        else $error("master request while unit idle");
    master_hold_a: assert property (m_req_r && !m_done |=>
        m_req_r && $stable(m_addr_r) && $stable(m_wr_r))
        else $error("master request changed before answer");
    remap_end_a: assert property (m_req_r && m_done |=>
        !m_req_r && hs_done_r)
        else $error("remap did not end after master answer");
    rdata_pass_a: assert property (m_req_r && m_done && !m_wr_r |=>
        hs_rdata_r == $past(m_rdata))
        else $error("remapped read data lost");
    master_cause_a: assert property ($rose(m_req_r) |-> $past(hs_req))
        else $error("master request without channel request");
endmodule : sar_unit_sva

bind sar_unit sar_unit_sva i_sva (.clk(clk), .rst(rst), .pb_sel(pb_sel),
    .pb_wr(pb_wr), .pb_addr(pb_addr), .pb_rdata_r(pb_rdata_r),
    .pb_ready_r(pb_ready_r), .hs_req(hs_req), .hs_rdata_r(hs_rdata_r),
    .hs_done_r(hs_done_r), .hs_err_r(hs_err_r), .hs_busy_r(hs_busy_r),
    .m_req_r(m_req_r), .m_wr_r(m_wr_r), .m_addr_r(m_addr_r),
    .m_rdata(m_rdata), .m_done(m_done));

// file: bench/sar_slave_model.sv
// Purpose: High-speed-bus slave answering the remap master port
// Assumes: Latency and error reply commanded by the bench
// Notes:   Read data is the inverted address; idle data churns
`timescale 1ns/1ps
module sar_slave_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        m_req,
    input  wire logic [31:0] m_addr,
    input  wire logic [1:0]  lat,
    input  wire logic        bad,
    output logic      [31:0] m_rdata,
    output logic             m_done,
    output logic             m_err
);
    logic [1:0]  cnt_r;
    logic [31:0] pat_r;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r   <= 2'h0;
            pat_r   <= 32'h0;
            m_rdata <= 32'h0;
            m_done  <= 1'b0;
            m_err   <= 1'b0;
        end
        else
        begin
            m_done  <= 1'b0;
            m_err   <= 1'b0;
            pat_r   <= pat_r + 32'h9E3779B9;
            m_rdata <= pat_r;
            if (m_req && !m_done)
            begin
                if (cnt_r >= lat)
                begin
                    m_done  <= 1'b1;
                    m_err   <= bad;
                    m_rdata <= ~m_addr;
                    cnt_r   <= 2'h0;
                end
                else
                    cnt_r <= cnt_r + 2'h1;
            end
        end
    end
endmodule : sar_slave_model

// file: bench/sar_unit_test.sv
// Purpose: Self-checking bench for the secure access remap unit
// Assumes: Expected results queued by drivers, checked by monitors
// Notes:   Key 5A, window 8 cycles, channel 0 remapped to FFFC0010
`timescale 1ns/1ps
module sar_unit_test;
    logic        clk, rst, pb_sel, pb_wr, pb_ready_r;
    logic [7:0]  pb_addr, hs_addr;
    logic [31:0] pb_wdata, pb_rdata_r, hs_wdata, hs_rdata_r;
    logic        hs_req, hs_wr, hs_done_r, hs_err_r, hs_busy_r;
    logic        m_req_r, m_wr_r, m_done, m_err, bad, irq;
    logic [31:0] m_addr_r, m_rdata, m_wdata, r;
    logic [1:0]  lat;
    logic [32:0] pq[$];
    logic [33:0] hq[$];
    logic [7:0]  wo[6] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h20, 8'h30};
    int          num_errors, samples_checked;
    localparam logic [31:0] TGT = 32'hFFFC0010;

    sar_unit i_dut (.clk(clk), .rst(rst), .pb_sel(pb_sel), .pb_wr(pb_wr),
        .pb_addr(pb_addr), .pb_wdata(pb_wdata), .pb_rdata_r(pb_rdata_r),
        .pb_ready_r(pb_ready_r), .hs_req(hs_req), .hs_wr(hs_wr),
        .hs_addr(hs_addr), .hs_wdata(hs_wdata), .hs_rdata_r(hs_rdata_r),
        .hs_done_r(hs_done_r), .hs_err_r(hs_err_r), .hs_busy_r(hs_busy_r),
        .m_req_r(m_req_r), .m_wr_r(m_wr_r), .m_addr_r(m_addr_r),
        .m_wdata_r(m_wdata), .m_rdata(m_rdata), .m_done(m_done),
        .m_err(m_err), .irq_r(irq));
    sar_slave_model i_slv (.clk(clk), .rst(rst), .m_req(m_req_r),
        .m_addr(m_addr_r), .lat(lat), .bad(bad), .m_rdata(m_rdata),
        .m_done(m_done), .m_err(m_err));

    task automatic cmp(input string n, input logic [31:0] e, s);
        samples_checked++;
        if (e !== s)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : cmp

    task automatic pbx(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        pq.push_back({!w, d});
        @(negedge clk);
        pb_sel   = 1'b1;
        pb_wr    = w;
        pb_addr  = a;
        pb_wdata = d;
        @(negedge clk);
        pb_sel = 1'b0;
    endtask : pbx

    task automatic hx(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic e, c,
                      input logic [31:0] x);
        int i;
        hq.push_back({c, e, x});
        @(negedge clk);
        hs_req   = 1'b1;
        hs_wr    = w;
        hs_addr  = a;
        hs_wdata = d;
        i = 0;
        do
        begin
            @(negedge clk);
            i++;
        end while (!hs_done_r && i < 40);
        if (hs_done_r !== 1'b1)
            cmp("hs_done_r", 32'h1, 32'h0);
        hs_req = 1'b0;
    endtask : hx

    task automatic report_and_stop;
        if (num_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Result monitors take the oldest note per answer
    always @(negedge clk)
    begin
        if (pb_ready_r === 1'b1 && pq.size() > 0)
        begin
            if (pq[0][32])
                cmp("pb_rdata_r", pq[0][31:0], pb_rdata_r);
            void'(pq.pop_front());
        end
        if (hs_done_r === 1'b1 && hq.size() > 0)
        begin
            cmp("hs_err_r", {31'h0, hq[0][32]}, {31'h0, hs_err_r});
            if (hq[0][33])
                cmp("hs_rdata_r", hq[0][31:0], hs_rdata_r);
            void'(hq.pop_front());
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #40000;
        num_errors++;
        report_and_stop;
    end

    initial
    begin
        {rst, pb_sel, pb_wr, hs_req, hs_wr, bad} = 6'h20;
        {pb_addr, hs_addr, pb_wdata, hs_wdata, lat} = 82'h0;
        r = $urandom(83);
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        pbx(0, 8'h10, 32'h400);
        foreach (wo[i]) pbx(0, wo[i], 32'h0);
        pbx(0, 8'h08, 32'h0);
        pbx(0, 8'h0C, 32'h0);
        pbx(1, 8'h00, 32'h1); pbx(0, 8'h10, 32'h500);
        pbx(1, 8'h00, 32'h0); pbx(0, 8'h10, 32'h500);
        pbx(1, 8'h00, 32'h4); pbx(0, 8'h10, 32'h700);
        hx(1, 8'h00, TGT, 0, 0, 0); hx(0, 8'h00, 0, 0, 1, TGT);
        hx(1, 8'h04, 32'h12340000, 0, 0, 0); pbx(0, 8'h10, 32'h780);
        pbx(1, 8'h20, 32'h80); pbx(0, 8'h10, 32'h700);
        pbx(1, 8'h00, 32'h8); pbx(0, 8'h10, 32'h500);
        r = $urandom;
        pbx(1, 8'h0C, r); pbx(0, 8'h0C, r);
        r = $urandom & 32'h7FFFFFFF;
        pbx(1, 8'h08, r); pbx(0, 8'h08, r);
        pbx(1, 8'h0C, 32'h1); pbx(1, 8'h08, 32'h0);
        lat = 2'($urandom);
        pbx(1, 8'h04, 32'h85A);
        hx(0, 8'h00, 0, 0, 0, 0); pbx(0, 8'h10, 32'h504);
        hx(1, 8'hFC, 32'h5A00, 0, 0, 0); pbx(0, 8'h10, 32'h524);
        pbx(1, 8'h20, 32'hFF);
        hx(1, 8'hFC, 32'h3300, 0, 0, 0); pbx(0, 8'h10, 32'h510);
        pbx(1, 8'h20, 32'hFF);
        hx(1, 8'hFC, 32'h5A00, 0, 0, 0);
        repeat (5) @(negedge clk);
        hx(0, 8'h00, 0, 0, 1, ~TGT); pbx(0, 8'h10, 32'h502);
        pbx(1, 8'h20, 32'hFF);
        hx(1, 8'hFC, 32'h5A00, 0, 0, 0);
        repeat (14) @(negedge clk);
        pbx(0, 8'h10, 32'h501);
        pbx(1, 8'h20, 32'hFF);
        // Unlocking channel 1 must relock channel 0
        hx(1, 8'hFC, 32'h5A00, 0, 0, 0);
        hx(1, 8'hFC, 32'h5A01, 0, 0, 0);
        hx(0, 8'h00, 0, 0, 0, 0);
        repeat (12) @(negedge clk);
        pbx(0, 8'h10, 32'h505);
        pbx(1, 8'h20, 32'hFF);
        hx(0, 8'hFC, 0, 0, 0, 0); pbx(0, 8'h10, 32'h508);
        pbx(1, 8'h20, 32'hFF);
        pbx(1, 8'h00, 32'h10); hx(0, 8'hFC, 0, 1, 0, 0);
        pbx(1, 8'h20, 32'hFF);
        pbx(1, 8'h00, 32'h20); hx(0, 8'hFC, 0, 0, 0, 0);
        pbx(1, 8'h20, 32'hFF);
        lat = 2'($urandom);
        pbx(1, 8'h04, 32'h1085A);
        hx(0, 8'h04, 0, 0, 0, 0); pbx(0, 8'h10, 32'h504);
        pbx(1, 8'h20, 32'hFF);
        hx(0, 8'h00, 0, 0, 1, ~TGT); pbx(0, 8'h10, 32'h500);
        hx(1, 8'h00, r, 0, 0, 0);
        cmp("m_wdata_r", r, m_wdata);
        cmp("m_addr_r", TGT, m_addr_r);
        pbx(1, 8'h00, 32'h10);
        bad = 1'b1;
        hx(0, 8'h00, 0, 1, 0, 0); pbx(0, 8'h10, 32'h540);
        bad = 1'b0;
        pbx(1, 8'h20, 32'hFF);
        pbx(1, 8'h14, 32'hFF); pbx(0, 8'h1C, 32'hFF);
        pbx(1, 8'h18, 32'h0F); pbx(0, 8'h1C, 32'hF0);
        hx(1, 8'hFC, 32'h3300, 0, 0, 0);
        repeat (2) @(negedge clk);
        cmp("irq_r", 32'h1, {31'h0, irq});
        pbx(1, 8'h20, 32'hFF);
        @(negedge clk);
        cmp("irq_r", 32'h0, {31'h0, irq});
        pbx(1, 8'h00, 32'h2); pbx(0, 8'h10, 32'h400);
        repeat (2) @(negedge clk);
        report_and_stop;
    end
endmodule : sar_unit_test
